// [uei_regs.sv]
// Endpoint interrupt summary, FIFO port, byte count, frame number, divider
`timescale 1ns/10ps
`default_nettype none
module uei_regs
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic [1:0]  endpoint_select,
    input  wire logic [2:0]  endpoint_is_iso,
    input  wire logic [2:0]  in_packet_sent,
    input  wire logic [2:0]  in_packet_acked,
    input  wire logic [2:0]  in_transmit_clear,
    output logic      [2:0]  in_transmit_complete,
    input  wire logic [2:0]  out_bank_zero_received,
    input  wire logic [2:0]  out_bank_one_received,
    input  wire logic [2:0]  setup_received,
    input  wire logic [2:0]  stall_sent_or_crc_error,
    output logic             usb_irq,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic [7:0]  rx_data,
    input  wire logic [1:0]  rx_ep,
    input  wire logic        rx_packet_done,
    input  wire logic [1:0]  rx_packet_ep,
    input  wire logic [6:0]  rx_packet_bytes,
    input  wire logic        tx_req,
    input  wire logic [1:0]  tx_ep,
    output logic             tx_grant,
    output logic [7:0]       tx_data,
    output logic             tx_data_valid,
    input  wire logic        sof_pid_seen,
    input  wire logic        sof_done,
    input  wire logic        sof_crc_ok,
    input  wire logic [10:0] sof_frame,
    output logic             sof_irq,
    output logic             usb_clk_en
);
    localparam int NE = uei_pkg::NUM_EP;
    localparam int PW = uei_pkg::PTR_W;

    logic [NE-1:0] src;
    logic [NE-1:0] src_q;
    logic [NE-1:0] irq_flag;
    logic [NE-1:0] irq_en;
    logic [uei_pkg::FRAME_W-1:0] frame;
    logic sof_crc_good;
    logic sof_crc_bad;
    logic [uei_pkg::DIV_W-1:0] div_field;
    logic [uei_pkg::DIV_W-1:0] div_cnt;
    logic [uei_pkg::BYCT_W-1:0] byte_cnt [NE];
    logic [PW:0] wr_ptr [NE];
    logic [PW:0] rd_ptr [NE];
    logic [7:0] reg_q;
    logic rd_fifo_q;

    function automatic logic is_full(input logic [PW:0] w,
                                     input logic [PW:0] r);
        is_full = (w[PW] != r[PW]) && (w[PW-1:0] == r[PW-1:0]);
    endfunction : is_full

    // Sources outside the selected range never touch the FIFO
    logic acc_data;
    logic cpu_wr;
    logic cpu_rd;
    assign acc_data = (sfr_addr == uei_pkg::ADDR_FIFO_DATA)
                      && (endpoint_select < 2'(NE));
    assign cpu_wr = sfr_wr && acc_data
                    && !is_full(wr_ptr[endpoint_select],
                                rd_ptr[endpoint_select]);
    assign cpu_rd = sfr_rd && acc_data
                    && (wr_ptr[endpoint_select] != rd_ptr[endpoint_select]);

    // Transmit complete, set wins over clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            in_transmit_complete <= '0;
        else
            in_transmit_complete <= (in_transmit_complete
                                     & ~in_transmit_clear)
                | (in_packet_sent & endpoint_is_iso)
                | (in_packet_acked & ~endpoint_is_iso);
    end

    assign src = in_transmit_complete | out_bank_zero_received
                 | out_bank_one_received | setup_received
                 | stall_sent_or_crc_error;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_q    <= '0;
            irq_flag <= '0;
        end
        else
        begin
            src_q <= src;
            for (int e = 0; e < NE; e++)
            begin
                if (src[e] && !src_q[e])
                    irq_flag[e] <= 1'b1;
                else if (!src[e])
                    irq_flag[e] <= 1'b0;
            end
        end
    end

    assign usb_irq = |(irq_flag & irq_en);

    // Software-writable registers; reserved bits are dropped
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_en    <= '0;
            div_field <= uei_pkg::DIV_RESET;
        end
        else if (sfr_wr)
        begin
            if (sfr_addr == uei_pkg::ADDR_IRQ_EN)
                irq_en <= sfr_wdata[NE-1:0];
            if (sfr_addr == uei_pkg::ADDR_CLK_DIV)
                div_field <= sfr_wdata[uei_pkg::DIV_W-1:0];
        end
    end

    // Divide by field plus one; raising it mid-count delays a tick, lowering it below the count ticks at once
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt    <= '0;
            usb_clk_en <= 1'b0;
        end
        else if (div_cnt >= div_field)
        begin
            div_cnt    <= '0;
            usb_clk_en <= 1'b1;
        end
        else
        begin
            div_cnt    <= div_cnt + 2'h1;
            usb_clk_en <= 1'b0;
        end
    end

    // Frame number and SOF status
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frame        <= '0;
            sof_crc_good <= 1'b0;
            sof_crc_bad  <= 1'b0;
            sof_irq      <= 1'b0;
        end
        else
        begin
            sof_irq <= sof_pid_seen;
            if (sof_done)
            begin
                sof_crc_good <= sof_crc_ok;
                sof_crc_bad  <= !sof_crc_ok;
                if (sof_crc_ok)
                    frame <= sof_frame;
            end
        end
    end

    // Received byte count per endpoint
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int e = 0; e < NE; e++)
                byte_cnt[e] <= '0;
        end
        else if (rx_packet_done && rx_packet_ep < 2'(NE))
            byte_cnt[rx_packet_ep] <= rx_packet_bytes;
    end

    // Two-entry buffer between the receive stream and the FIFO
    logic [9:0] buf_d [2];
    logic [1:0] buf_cnt;
    logic buf_out_valid;
    logic buf_out_ready;
    logic buf_push;
    logic buf_pop;
    logic [1:0] head_ep;

    assign head_ep = buf_d[0][9:8];
    assign rx_ready = (buf_cnt != uei_pkg::BUF_FULL);
    assign buf_out_valid = (buf_cnt != 2'h0);
    // CPU writes own the RAM port; a full endpoint stalls the stream
    assign buf_out_ready = !cpu_wr && (head_ep >= 2'(NE)
                           || !is_full(wr_ptr[head_ep], rd_ptr[head_ep]));
    assign buf_push = rx_valid && rx_ready;
    assign buf_pop = buf_out_valid && buf_out_ready;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_cnt  <= '0;
            buf_d[0] <= '0;
            buf_d[1] <= '0;
        end
        else
        begin
            buf_cnt <= buf_cnt + 2'(buf_push) - 2'(buf_pop);
            if (buf_pop)
                buf_d[0] <= buf_d[1];
            if (buf_push)
            begin
                if (buf_cnt == 2'h0 || (buf_cnt == 2'h1 && buf_pop))
                    buf_d[0] <= {rx_ep, rx_data};
                else
                    buf_d[1] <= {rx_ep, rx_data};
            end
        end
    end

    // FIFO pointers; bytes for an unknown endpoint are discarded
    logic ram_we;
    logic ram_re;
    logic [uei_pkg::RAM_AW-1:0] ram_waddr;
    logic [uei_pkg::RAM_AW-1:0] ram_raddr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_q;
    logic [1:0] w_ep;
    logic [1:0] r_ep;

    assign w_ep = cpu_wr ? endpoint_select : head_ep;
    assign ram_we = cpu_wr || (buf_pop && head_ep < 2'(NE));
    assign ram_wdata = cpu_wr ? sfr_wdata : buf_d[0][7:0];
    assign ram_waddr = {w_ep, wr_ptr[w_ep][PW-1:0]};
    assign tx_grant = tx_req && !cpu_rd && tx_ep < 2'(NE)
                      && (wr_ptr[tx_ep] != rd_ptr[tx_ep]);
    assign r_ep = cpu_rd ? endpoint_select : tx_ep;
    assign ram_re = cpu_rd || tx_grant;
    assign ram_raddr = {r_ep, rd_ptr[r_ep][PW-1:0]};

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int e = 0; e < NE; e++)
            begin
                wr_ptr[e] <= '0;
                rd_ptr[e] <= '0;
            end
        end
        else
        begin
            if (ram_we)
                wr_ptr[w_ep] <= wr_ptr[w_ep] + 5'h1;
            if (ram_re)
                rd_ptr[r_ep] <= rd_ptr[r_ep] + 5'h1;
        end
    end

    uei_fifo_ram u_ram
    (
        .clock (clock),
        .rst_n (rst_n),
        .we    (ram_we),
        .waddr (ram_waddr),
        .wdata (ram_wdata),
        .re    (ram_re),
        .raddr (ram_raddr),
        .rdata (ram_q)
    );

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tx_data_valid <= 1'b0;
        else
            tx_data_valid <= tx_grant;
    end
    assign tx_data = ram_q;

    // Register reads answer one cycle after the strobe
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_q     <= uei_pkg::RESET_BYTE;
            rd_fifo_q <= 1'b0;
        end
        else
        begin
            if (sfr_rd)
            begin
                // Held until the next read so FIFO data stands too
                rd_fifo_q <= acc_data;
                unique case (sfr_addr)
                    uei_pkg::ADDR_FRAME_LO:
                        reg_q <= frame[7:0];
                    uei_pkg::ADDR_FRAME_HI:
                        reg_q <= {2'h0, sof_crc_good, sof_crc_bad,
                                  1'b0, frame[10:8]};
                    uei_pkg::ADDR_IRQ_EN:
                        reg_q <= {5'h0, irq_en};
                    uei_pkg::ADDR_BYTE_CNT:
                        reg_q <= (endpoint_select < 2'(NE))
                            ? {1'b0, byte_cnt[endpoint_select]}
                            : 8'h00;
                    uei_pkg::ADDR_CLK_DIV:
                        reg_q <= {6'h0, div_field};
                    uei_pkg::ADDR_IRQ_SUM:
                        reg_q <= {5'h0, irq_flag};
                    default:
                        reg_q <= 8'h00;
                endcase
            end
        end
    end

    // Empty FIFO read returns the last byte the RAM produced
    assign sfr_rdata = rd_fifo_q ? ram_q : reg_q;

    property p_flag_set;
        @(posedge clock) disable iff (!rst_n)
        (src[0] && !src_q[0]) |=> irq_flag[0];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("summary flag not set");

    property p_flag_hold;
        @(posedge clock) disable iff (!rst_n)
        (irq_flag[1] && src[1]) |=> irq_flag[1];
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("summary flag cleared early");

    property p_flag_clear;
        @(posedge clock) disable iff (!rst_n)
        !src[2] |=> !irq_flag[2];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("summary flag stuck");

    property p_irq;
        @(posedge clock) disable iff (!rst_n)
        (src[0] && !src_q[0] && irq_en[0]) |=> usb_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing");

    property p_frame_hold;
        @(posedge clock) disable iff (!rst_n)
        (sof_done && !sof_crc_ok) |=> $stable(frame) && sof_crc_bad
            && !sof_crc_good;
    endproperty
    a_frame_hold: assert property (p_frame_hold)
        else $error("frame changed on bad sof");

    property p_frame_take;
        @(posedge clock) disable iff (!rst_n)
        (sof_done && sof_crc_ok) |=> frame == $past(sof_frame)
            && sof_crc_good && !sof_crc_bad;
    endproperty
    a_frame_take: assert property (p_frame_take)
        else $error("good sof not taken");

    property p_sof_irq;
        @(posedge clock) disable iff (!rst_n)
        sof_pid_seen |=> sof_irq;
    endproperty
    a_sof_irq: assert property (p_sof_irq)
        else $error("sof interrupt late");

    property p_div3;
        @(posedge clock) disable iff (!rst_n)
        (usb_clk_en && div_field == 2'h3 && $stable(div_field))
            |=> !usb_clk_en [*3] ##1 usb_clk_en;
    endproperty
    a_div3: assert property (p_div3)
        else $error("divider period wrong");

    property p_in_transmit_complete;
        @(posedge clock) disable iff (!rst_n)
        (in_packet_acked[1] && !endpoint_is_iso[1]) |=>
            in_transmit_complete[1];
    endproperty
    a_in_transmit_complete: assert property (p_in_transmit_complete)
        else $error("tx complete not set");

    property p_push;
        @(posedge clock) disable iff (!rst_n)
        (cpu_wr && endpoint_select == 2'h0) |=>
            wr_ptr[0] == $past(wr_ptr[0]) + 5'h1;
    endproperty
    a_push: assert property (p_push)
        else $error("fifo push lost");

    property p_rsvd;
        @(posedge clock) disable iff (!rst_n)
        (sfr_rd && sfr_addr == uei_pkg::ADDR_FRAME_HI) |=>
            sfr_rdata[7:6] == 2'h0 && !sfr_rdata[3];
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits nonzero");
endmodule : uei_regs
`default_nettype wire

// [uei_pkg.sv]
// Constants shared by the endpoint interrupt and frame register block
package uei_pkg;
    localparam logic [7:0] ADDR_FRAME_LO  = 8'hba;
    localparam logic [7:0] ADDR_FRAME_HI  = 8'hbb;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'hc2;
    localparam logic [7:0] ADDR_FIFO_DATA = 8'hcf;
    localparam logic [7:0] ADDR_BYTE_CNT  = 8'he2;
    localparam logic [7:0] ADDR_CLK_DIV   = 8'hea;
    localparam logic [7:0] ADDR_IRQ_SUM   = 8'hf8;
    localparam int NUM_EP      = 3;
    localparam int EP_W        = 2;
    localparam int PTR_W       = 4;
    localparam int FIFO_DEPTH  = 16;
    localparam int RAM_AW      = EP_W + PTR_W;
    localparam int FRAME_W     = 11;
    localparam int BYCT_W      = 7;
    localparam int DIV_W       = 2;
    localparam int CRC_GOOD_BIT = 5;
    localparam int CRC_BAD_BIT  = 4;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RESET = 2'h0;
    localparam logic [1:0] BUF_FULL = 2'h2;
endpackage : uei_pkg

// [uei_fifo_ram.sv]
// Endpoint FIFO storage, one write and one registered read port
`timescale 1ns/10ps
`default_nettype none
module uei_fifo_ram
(
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    input  wire logic                     we,
    input  wire logic [uei_pkg::RAM_AW-1:0] waddr,
    input  wire logic [7:0]               wdata,
    input  wire logic                     re,
    input  wire logic [uei_pkg::RAM_AW-1:0] raddr,
    output logic      [7:0]               rdata
);
    logic [7:0] mem [0:(1<<uei_pkg::RAM_AW)-1];

    // Array left unreset so it maps to RAM
    always_ff @(posedge clock)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= uei_pkg::RESET_BYTE;
        else if (re)
            rdata <= mem[raddr];
    end
endmodule : uei_fifo_ram
`default_nettype wire

// [uei_host_model.sv]
// Behavioural bus side: receive stream, transmit pull, SOF and packet ends
`timescale 1ns/10ps
`default_nettype none
module uei_host_model
(
    input  wire logic        clock,
    input  wire logic        rx_ready,
    input  wire logic        tx_grant,
    output logic             rx_valid,
    output logic [7:0]       rx_data,
    output logic [1:0]       rx_ep,
    output logic             tx_req,
    output logic [1:0]       tx_ep,
    output logic             sof_pid_seen,
    output logic             sof_done,
    output logic             sof_crc_ok,
    output logic [10:0]      sof_frame,
    output logic             rx_packet_done,
    output logic [1:0]       rx_packet_ep,
    output logic [6:0]       rx_packet_bytes
);
    int timeouts = 0;
    initial
    begin
        {rx_valid, rx_ep, tx_req, tx_ep, sof_pid_seen, sof_done} = '0;
        {rx_packet_done, rx_packet_ep, rx_packet_bytes} = '0;
        {rx_data, sof_crc_ok, sof_frame} = 20'h5a2a5;
    end
    task send(input logic [1:0] ep, input logic [7:0] d);
        int n;
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_ep <= ep;
        rx_data <= d;
        n = 0;
        do begin @(posedge clock); n++; end while (!rx_ready && n < 50);
        if (n == 50) timeouts++;
        rx_valid <= 1'b0;
        // Released line must not keep showing the last byte
        rx_data <= ~d;
    endtask : send
    task pull(input logic [1:0] ep, input int n);
        int k, w, st;
        @(posedge clock);
        for (k = 0; k < n; k++)
        begin
            tx_req <= 1'b1;
            tx_ep <= ep;
            w = 0;
            do begin @(posedge clock); w++; end while (!tx_grant && w < 50);
            if (w == 50) timeouts++;
            // Random stalls; zero keeps the request up back to back
            st = $urandom_range(2);
            if (st != 0 || k == n - 1)
            begin
                tx_req <= 1'b0;
                repeat (st) @(posedge clock);
            end
        end
    endtask : pull
    task sof(input logic [10:0] f, input logic ok);
        @(posedge clock);
        sof_pid_seen <= 1'b1;
        @(posedge clock);
        sof_pid_seen <= 1'b0;
        // Frame and CRC arrive well after the PID
        repeat (3) @(posedge clock);
        sof_done <= 1'b1;
        sof_frame <= f;
        sof_crc_ok <= ok;
        @(posedge clock);
        sof_done <= 1'b0;
        sof_frame <= ~f;
        sof_crc_ok <= ~ok;
    endtask : sof
    task packet(input logic [1:0] ep, input logic [6:0] n);
        @(posedge clock);
        rx_packet_done <= 1'b1;
        rx_packet_ep <= ep;
        rx_packet_bytes <= n;
        @(posedge clock);
        rx_packet_done <= 1'b0;
        rx_packet_bytes <= ~n;
    endtask : packet
endmodule : uei_host_model
`default_nettype wire

// [usb_endpoint_irq_frame_regs_tb.sv]
// Self-checking bench for the endpoint interrupt and frame registers
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_irq_frame_regs_tb;
    logic clock = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
    logic [1:0] endpoint_select = 2'h0;
    logic [2:0] endpoint_is_iso = 3'h0, in_packet_sent = 3'h0;
    logic [2:0] in_packet_acked = 3'h0, in_transmit_clear = 3'h0;
    logic [11:0] lv = 12'h000;
    wire logic [7:0] sfr_rdata, rx_data, tx_data;
    wire logic [2:0] in_transmit_complete;
    wire logic [1:0] rx_ep, tx_ep, rx_packet_ep;
    wire logic [6:0] rx_packet_bytes;
    wire logic [10:0] sof_frame;
    wire logic usb_irq, rx_valid, rx_ready, rx_packet_done, tx_req, tx_grant;
    wire logic tx_data_valid, sof_pid_seen, sof_done, sof_crc_ok, sof_irq;
    wire logic usb_clk_en;
    int failures = 0, n_tests = 0, i, j, k, n;
    logic [7:0] rq[$], tq[$], dq[$], b;
    logic [10:0] f, fr;
    logic rd_q = 1'b0, pid_q = 1'b0, m;
    always #2.5 clock = ~clock;
    uei_regs i_dut (.clock, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata, .endpoint_select, .endpoint_is_iso, .in_packet_sent,
        .in_packet_acked, .in_transmit_clear, .in_transmit_complete,
        .out_bank_zero_received(lv[2:0]), .out_bank_one_received(lv[5:3]),
        .setup_received(lv[8:6]), .stall_sent_or_crc_error(lv[11:9]),
        .usb_irq, .rx_valid, .rx_ready, .rx_data, .rx_ep, .rx_packet_done,
        .rx_packet_ep, .rx_packet_bytes, .tx_req, .tx_ep, .tx_grant, .tx_data,
        .tx_data_valid, .sof_pid_seen, .sof_done, .sof_crc_ok, .sof_frame,
        .sof_irq, .usb_clk_en);
    uei_host_model i_host (.clock, .rx_ready, .tx_grant, .rx_valid, .rx_data,
        .rx_ep, .tx_req, .tx_ep, .sof_pid_seen, .sof_done, .sof_crc_ok,
        .sof_frame, .rx_packet_done, .rx_packet_ep, .rx_packet_bytes);
    task chk(input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk
    task test_done;
        failures += i_host.timeouts;
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clock);
        sfr_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        rq.push_back(e);
        @(posedge clock);
        sfr_rd <= 1'b0;
    endtask : rd
    task cyc(input int c);
        repeat (c) @(posedge clock);
    endtask : cyc
    // Results are compared where they appear, oldest note first
    always @(posedge clock)
    begin
        if (rd_q) chk(rq.pop_front(), sfr_rdata);
        if (tx_data_valid) chk(tq.pop_front(), tx_data);
        if (pid_q | sof_irq) chk({7'h0, pid_q}, {7'h0, sof_irq});
        rd_q <= sfr_rd;
        pid_q <= sof_pid_seen;
    end
    initial
    begin
        cyc(50000);
        failures++;
        test_done();
    end
    initial
    begin
        void'($urandom(80));
        cyc(4);
        rst_n <= 1'b1;
        rd(uei_pkg::ADDR_FRAME_LO, 8'h00);
        rd(uei_pkg::ADDR_FRAME_HI, 8'h00);
        rd(uei_pkg::ADDR_BYTE_CNT, 8'h00);
        rd(uei_pkg::ADDR_CLK_DIV, 8'h00);
        rd(uei_pkg::ADDR_IRQ_SUM, 8'h00);
        // Software keeps reserved bits at zero; they must read back zero
        wr(uei_pkg::ADDR_CLK_DIV, 8'h01);
        rd(uei_pkg::ADDR_CLK_DIV, 8'h01);
        wr(uei_pkg::ADDR_CLK_DIV, 8'h03);
        for (i = 0; i < 3; i++)
        begin
            n = 0;
            do begin @(posedge clock); n++; end while (!usb_clk_en && n < 9);
        end
        chk(8'd4, 8'(n));
        for (i = 0; i < 3; i++)
        begin
            wr(uei_pkg::ADDR_IRQ_EN, 8'h01 << i);
            rd(uei_pkg::ADDR_IRQ_EN, 8'h01 << i);
            @(posedge clock) in_packet_sent <= 3'h1 << i;
            @(posedge clock) in_packet_sent <= 3'h0;
            cyc(2);
            chk(8'h00, {5'h0, in_transmit_complete});
            @(posedge clock) in_packet_acked <= 3'h1 << i;
            @(posedge clock) in_packet_acked <= 3'h0;
            cyc(2);
            chk(8'h01 << i, {5'h0, in_transmit_complete});
            chk(8'h01, {7'h0, usb_irq});
            rd(uei_pkg::ADDR_IRQ_SUM, 8'h01 << i);
            @(posedge clock) lv[i] <= 1'b1;
            @(posedge clock) in_transmit_clear <= 3'h1 << i;
            @(posedge clock) in_transmit_clear <= 3'h0;
            cyc(2);
            rd(uei_pkg::ADDR_IRQ_SUM, 8'h01 << i);
            @(posedge clock) lv[i] <= 1'b0;
            cyc(2);
            rd(uei_pkg::ADDR_IRQ_SUM, 8'h00);
            chk(8'h00, {7'h0, usb_irq});
            for (k = 1; k < 4; k++)
            begin
                // Last pass enables only the other endpoints
                m = (k != 3);
                b = m ? 8'h01 << i : 8'h07 ^ (8'h01 << i);
                wr(uei_pkg::ADDR_IRQ_EN, b);
                @(posedge clock) lv[3 * k + i] <= 1'b1;
                cyc(2);
                rd(uei_pkg::ADDR_IRQ_SUM, 8'h01 << i);
                chk({7'h0, m}, {7'h0, usb_irq});
                @(posedge clock) lv[3 * k + i] <= 1'b0;
            end
            @(posedge clock) endpoint_is_iso <= 3'h1 << i;
            @(posedge clock) in_packet_sent <= 3'h1 << i;
            @(posedge clock) in_packet_sent <= 3'h0;
            cyc(2);
            chk(8'h01 << i, {5'h0, in_transmit_complete});
            @(posedge clock) in_transmit_clear <= 3'h1 << i;
            @(posedge clock) in_transmit_clear <= 3'h0;
            endpoint_is_iso <= 3'h0;
        end
        // One byte past the depth is dropped
        @(posedge clock) endpoint_select <= 2'h1;
        for (j = 0; j < 17; j++)
        begin
            b = 8'($urandom);
            wr(uei_pkg::ADDR_FIFO_DATA, b);
            if (j < 16) dq.push_back(b);
        end
        for (j = 0; j < 16; j++)
            rd(uei_pkg::ADDR_FIFO_DATA, dq.pop_front());
        for (j = 0; j < 18; j++)
        begin
            b = 8'($urandom);
            i_host.send(2'h2, b);
            dq.push_back(b);
        end
        cyc(2);
        chk(8'h00, {7'h0, rx_ready});
        @(posedge clock) endpoint_select <= 2'h2;
        for (j = 0; j < 18; j++)
            rd(uei_pkg::ADDR_FIFO_DATA, dq.pop_front());
        @(posedge clock) endpoint_select <= 2'h0;
        for (j = 0; j < 6; j++)
        begin
            b = 8'($urandom);
            wr(uei_pkg::ADDR_FIFO_DATA, b);
            tq.push_back(b);
        end
        i_host.pull(2'h0, 6);
        cyc(3);
        chk(8'h00, 8'(tq.size()));
        for (i = 0; i < 3; i++) i_host.packet(2'(i), 7'(i * 50 + 27));
        for (i = 0; i < 3; i++)
        begin
            @(posedge clock) endpoint_select <= 2'(i);
            cyc(1);
            rd(uei_pkg::ADDR_BYTE_CNT, 8'(i * 50 + 27));
        end
        fr = 11'h000;
        for (j = 0; j < 4; j++)
        begin
            f = 11'($urandom);
            m = (j != 2);
            i_host.sof(f, m);
            cyc(2);
            if (m) fr = f;
            rd(uei_pkg::ADDR_FRAME_LO, fr[7:0]);
            b = {2'h0, m, !m, 1'b0, fr[10:8]};
            rd(uei_pkg::ADDR_FRAME_HI, b);
        end
        cyc(4);
        test_done();
    end
endmodule : usb_endpoint_irq_frame_regs_tb
`default_nettype wire
